//--- logic/nvac_osc_tick.sv
// tick generator: one-cycle pulse at the calibrated oscillator rate
`timescale 1ns/10ps
`default_nettype none
module nvac_osc_tick
  import nvac_pkg::*;
#(
  parameter int unsigned DIV = OSC_DIV_CYC
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic run,
  output logic      tick
);
  logic [7:0] cnt_q;
  wire        wrap = (cnt_q == 8'(DIV - 1));

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
      tick  <= 1'b0;
    end else begin
      cnt_q <= (!run || wrap) ? 8'h00 : cnt_q + 8'h01;
      tick  <= run && wrap;
    end
  end
endmodule : nvac_osc_tick
`default_nettype wire

//--- logic/nvac_pkg.sv
// package: register map, field positions and timing counts of the eeprom access controller
package nvac_pkg;

  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned CAL_OSC_HZ      = 1_000_000;
  localparam int unsigned WRITE_OSC_CYC   = 8448;
  localparam int unsigned MWE_HOLD_CYC    = 4;
  localparam int unsigned WR_STALL_CYC    = 2;
  localparam int unsigned RD_STALL_CYC    = 4;
  localparam int unsigned OSC_DIV_CYC     = CLK_HZ / CAL_OSC_HZ;

  localparam int unsigned NV_DEPTH        = 512;
  localparam int unsigned NV_AW           = 9;

  localparam logic [1:0] REG_CONTROL    = 2'h0;
  localparam logic [1:0] REG_DATA       = 2'h1;
  localparam logic [1:0] REG_ADDR_LOW   = 2'h2;
  localparam logic [1:0] REG_ADDR_HIGH  = 2'h3;

  localparam int unsigned CTL_READ_BIT  = 0;
  localparam int unsigned CTL_WRITE_BIT = 1;
  localparam int unsigned CTL_MWE_BIT   = 2;
  localparam int unsigned CTL_RIE_BIT   = 3;

  localparam logic [7:0] CONTROL_RESET  = 8'h00;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] sel;
    logic [7:0] wdata;
  } nvac_io_req_t;

  typedef enum logic [1:0] {NV_IDLE, NV_PROG} nvac_state_t;

endpackage : nvac_pkg

//--- logic/nvac_top.sv
// eeprom access controller: i/o registers, write timing, cpu stall and ready request
//
// Overview of operation
// - nine-bit address selects one of 512 bytes linearly, 0 to 511.
// - address bits 15..9 and control bits 7..4 always read zero.
// - address has no defined reset value; software loads it before access.
// - data register holds byte to write, and receives byte read.
// - ready request stays high while enabled, global enable set, strobe clear.
// - master write enable clears itself four clocks after software sets it.
// - write strobe with master enable set starts a write; otherwise ignored.
// - write strobe stays set during programming, hardware clears it after.
// - setting the write strobe stalls the cpu for two cycles.
// - read strobe fetches byte at once, then stalls cpu four cycles.
// - during a write, reads and address changes are refused.
// - write lasts 8448 cycles of the 1 MHz calibrated oscillator.
// - power-down sleep does not stop a running write; oscillator keeps running.
// - reset does not abort a running write; it completes.
`timescale 1ns/10ps
`default_nettype none
module nvac_top
  import nvac_pkg::*;
#(
  parameter int unsigned WRITE_CYC = WRITE_OSC_CYC,
  parameter int unsigned OSC_DIV   = OSC_DIV_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       por_n,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [1:0] io_sel,
  input  wire logic [7:0] io_wdata,
  input  wire logic       global_irq_en,
  input  wire logic       power_down_req,
  output logic      [7:0] io_rdata,
  output logic            cpu_stall,
  output logic            ready_irq,
  output logic            osc_run,
  output logic            power_down_ok
);

  ////////////////////////////////////////////////////////////////////////////
  // request decode
  nvac_io_req_t req;
  assign req = '{wr: io_wr, rd: io_rd, sel: io_sel, wdata: io_wdata};

  function automatic logic hit(input nvac_io_req_t r, input logic [1:0] s);
    hit = r.wr && (r.sel == s);
  endfunction : hit

  nvac_state_t          state_q, state_d;
  logic [7:0]           mem [NV_DEPTH];
  logic [NV_AW-1:0]     addr_q;
  logic [7:0]           data_q;
  logic                 rie_q, mwe_q;
  logic [2:0]           mwe_cnt_q;
  logic [2:0]           stall_cnt_q;
  logic [13:0]          prog_cnt_q;
  logic [NV_AW-1:0]     prog_addr_q;
  logic [7:0]           prog_data_q;
  logic                 osc_tick;

  wire busy       = (state_q == NV_PROG);
  wire wr_ctl     = hit(req, REG_CONTROL);
  wire set_mwe    = wr_ctl && req.wdata[CTL_MWE_BIT] && !req.wdata[CTL_WRITE_BIT];
  wire start_wr   = wr_ctl && req.wdata[CTL_WRITE_BIT] && mwe_q && !busy;
  wire start_rd   = wr_ctl && req.wdata[CTL_READ_BIT] && !busy;
  wire addr_wr_ok = !busy;
  wire prog_done  = busy && osc_tick && (prog_cnt_q == 14'(WRITE_CYC - 1));
  wire [NV_AW-1:0] addr_next = {hit(req, REG_ADDR_HIGH) && addr_wr_ok ? req.wdata[0]
                                 : addr_q[8],
                                hit(req, REG_ADDR_LOW) && addr_wr_ok ? req.wdata
                                 : addr_q[7:0]};

  always_comb begin
    state_d = state_q;
    case (state_q)
      NV_IDLE: if (start_wr) state_d = NV_PROG;
      NV_PROG: if (prog_done) state_d = NV_IDLE;
      default: state_d = NV_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // write engine: reset by power-on only, so a system reset leaves a write running
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      state_q    <= NV_IDLE;
      prog_cnt_q <= 14'h0000;
    end else begin
      state_q    <= state_d;
      prog_cnt_q <= !busy ? 14'h0000 : prog_cnt_q + 14'(osc_tick);
    end
  end

  always_ff @(posedge core_clk) begin
    if (start_wr) begin
      prog_addr_q <= addr_q;
      prog_data_q <= data_q;
    end
    if (prog_done) mem[prog_addr_q] <= prog_data_q;
  end

  nvac_osc_tick #(.DIV(OSC_DIV)) u_osc (
    .core_clk (core_clk),
    .nrst     (por_n),
    .run      (busy),
    .tick     (osc_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // address and data: no reset value
  always_ff @(posedge core_clk) begin
    addr_q <= addr_next;
    if (start_rd) data_q <= mem[addr_q];
    else if (hit(req, REG_DATA)) data_q <= req.wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next values of the outputs and the readback selection
  wire       stall_d      = start_wr || start_rd || (stall_cnt_q > 3'h1);
  wire       prog_d       = (state_d == NV_PROG);
  wire       ready_d      = rie_q && global_irq_en && !prog_d;
  wire       pd_ok_d      = power_down_req && !prog_d;
  wire [7:0] ctl_byte     = {4'h0, rie_q, mwe_q, busy, 1'b0};
  wire [7:0] addr_hi_byte = {7'h00, addr_q[8]};
  wire [7:0] sel_byte     = (io_sel == REG_CONTROL)  ? ctl_byte :
                            (io_sel == REG_DATA)     ? data_q :
                            (io_sel == REG_ADDR_LOW) ? addr_q[7:0] :
                                                       addr_hi_byte;
  wire [7:0] rdata_d      = io_rd ? sel_byte : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // control bits, stall and outputs
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rie_q         <= CONTROL_RESET[CTL_RIE_BIT];
      mwe_q         <= CONTROL_RESET[CTL_MWE_BIT];
      mwe_cnt_q     <= 3'h0;
      stall_cnt_q   <= 3'h0;
      cpu_stall     <= 1'b0;
      ready_irq     <= 1'b0;
      osc_run       <= 1'b0;
      power_down_ok <= 1'b0;
      io_rdata      <= 8'h00;
    end else begin
      if (wr_ctl) rie_q <= req.wdata[CTL_RIE_BIT];
      if (set_mwe) begin
        mwe_q     <= 1'b1;
        mwe_cnt_q <= 3'(MWE_HOLD_CYC);
      end else if (mwe_cnt_q != 3'h0) begin
        mwe_cnt_q <= mwe_cnt_q - 3'h1;
        mwe_q     <= (mwe_cnt_q != 3'h1);
      end
      if (start_wr) stall_cnt_q <= 3'(WR_STALL_CYC);
      else if (start_rd) stall_cnt_q <= 3'(RD_STALL_CYC);
      else if (stall_cnt_q != 3'h0) stall_cnt_q <= stall_cnt_q - 3'h1;
      cpu_stall     <= stall_d;
      ready_irq     <= ready_d;
      osc_run       <= prog_d;
      power_down_ok <= pd_ok_d;
      io_rdata      <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_mwe_timeout: assert property (@(posedge core_clk) disable iff (!nrst)
    set_mwe |=> mwe_q [*4] ##1 !mwe_q || set_mwe)
    else $error("master write enable did not time out after four cycles");
  chk_no_write_wo_mwe: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_ctl && req.wdata[CTL_WRITE_BIT] && !mwe_q && !busy) |=> !busy)
    else $error("write started without master enable");
  chk_wr_stall: assert property (@(posedge core_clk) disable iff (!nrst)
    start_wr |=> cpu_stall ##1 cpu_stall ##1 !cpu_stall)
    else $error("write stall is not two cycles");
  chk_rd_stall: assert property (@(posedge core_clk) disable iff (!nrst)
    start_rd |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall is not four cycles");
  chk_addr_frozen: assert property (@(posedge core_clk) disable iff (!nrst)
    (busy && $past(busy)) |-> $stable(addr_q))
    else $error("address changed during a write");
  chk_ready_level: assert property (@(posedge core_clk) disable iff (!nrst)
    ##1 ready_irq == ($past(rie_q) && $past(global_irq_en) && !busy))
    else $error("ready request does not follow enable and strobe");
  chk_reserved_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(io_rd) && ($past(io_sel) == REG_CONTROL) |-> io_rdata[7:4] == 4'h0
      && io_rdata[0] == 1'b0)
    else $error("reserved or read strobe bits read nonzero");
  chk_osc_runs: assert property (@(posedge core_clk) disable iff (!nrst)
    busy |-> ##1 osc_run || !busy)
    else $error("timing oscillator stopped during a write");

  // register and readback checks
  chk_addr_low_load: assert property (@(posedge core_clk) disable iff (!nrst)
    (hit(req, REG_ADDR_LOW) && addr_wr_ok) |=> addr_q[7:0] == $past(req.wdata))
    else $error("address low byte not loaded");

  chk_addr_high_load: assert property (@(posedge core_clk) disable iff (!nrst)
    (hit(req, REG_ADDR_HIGH) && addr_wr_ok) |=> addr_q[8] == $past(req.wdata[0]))
    else $error("address bit eight not loaded");

  chk_addr_high_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    ($past(io_rd) && ($past(io_sel) == REG_ADDR_HIGH)) |-> io_rdata[7:1] == 7'h00)
    else $error("unused address bits read nonzero");

  chk_data_load: assert property (@(posedge core_clk) disable iff (!nrst)
    hit(req, REG_DATA) |=> data_q == $past(req.wdata))
    else $error("data register not loaded");

  chk_write_latched: assert property (@(posedge core_clk) disable iff (!nrst)
    start_wr |=> (prog_addr_q == $past(addr_q)) && (prog_data_q == $past(data_q)))
    else $error("write address or data not captured");

  chk_mem_written: assert property (@(posedge core_clk) disable iff (!nrst)
    prog_done |=> mem[$past(prog_addr_q)] == $past(prog_data_q))
    else $error("byte not stored at end of write");

  chk_rie_load: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_ctl |=> rie_q == $past(req.wdata[CTL_RIE_BIT]))
    else $error("ready enable not loaded");

  chk_ready_low_busy: assert property (@(posedge core_clk) disable iff (!nrst)
    busy |-> !ready_irq)
    else $error("ready request high during a write");

  // master enable and write start
  chk_mwe_load: assert property (@(posedge core_clk) disable iff (!nrst)
    set_mwe |=> mwe_q && (mwe_cnt_q == 3'(MWE_HOLD_CYC)))
    else $error("master write enable not armed");

  chk_mwe_counting: assert property (@(posedge core_clk) disable iff (!nrst)
    mwe_q |-> mwe_cnt_q != 3'h0)
    else $error("master write enable without timeout count");

  chk_write_needs_mwe: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(busy) |-> $past(mwe_q && wr_ctl && req.wdata[CTL_WRITE_BIT]))
    else $error("write began without enabled strobe");

  chk_write_strobe_read: assert property (@(posedge core_clk) disable iff (!nrst)
    ($past(io_rd) && ($past(io_sel) == REG_CONTROL)) |-> io_rdata[CTL_WRITE_BIT] == $past(busy))
    else $error("write strobe readback differs from write state");

  chk_busy_holds: assert property (@(posedge core_clk) disable iff (!nrst)
    (busy && !prog_done) |=> busy)
    else $error("write ended early");

  chk_done_clears: assert property (@(posedge core_clk) disable iff (!nrst)
    prog_done |=> !busy)
    else $error("write strobe not cleared at end");

  // stall
  chk_stall_count: assert property (@(posedge core_clk) disable iff (!nrst)
    cpu_stall |-> stall_cnt_q != 3'h0)
    else $error("stall without stall count");

  chk_wr_stall_load: assert property (@(posedge core_clk) disable iff (!nrst)
    start_wr |=> stall_cnt_q == 3'(WR_STALL_CYC))
    else $error("write stall count not loaded");

  chk_rd_stall_load: assert property (@(posedge core_clk) disable iff (!nrst)
    (start_rd && !start_wr) |=> stall_cnt_q == 3'(RD_STALL_CYC))
    else $error("read stall count not loaded");

  chk_rd_fetch: assert property (@(posedge core_clk) disable iff (!nrst)
    start_rd |=> data_q == mem[$past(addr_q)])
    else $error("read strobe did not fetch the addressed byte");

  // refusals during a write and timing
  chk_rd_refused: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_ctl && req.wdata[CTL_READ_BIT] && busy) |=> data_q == $past(data_q))
    else $error("read performed during a write");

  chk_addr_refused: assert property (@(posedge core_clk) disable iff (!nrst)
    (busy && (hit(req, REG_ADDR_LOW) || hit(req, REG_ADDR_HIGH))) |=> addr_q == $past(addr_q))
    else $error("address accepted during a write");

  chk_prog_count_max: assert property (@(posedge core_clk) disable iff (!nrst)
    busy |-> prog_cnt_q < 14'(WRITE_CYC))
    else $error("write timing count overran");

  chk_tick_busy: assert property (@(posedge core_clk) disable iff (!nrst)
    osc_tick |-> $past(busy))
    else $error("timing tick outside a write");

  chk_pd_blocked: assert property (@(posedge core_clk) disable iff (!nrst)
    busy |-> !power_down_ok)
    else $error("power-down allowed during a write");

  cov_write: cover property (@(posedge core_clk) disable iff (!nrst) start_wr);
  cov_done:  cover property (@(posedge core_clk) disable iff (!nrst) prog_done);
  cov_read:  cover property (@(posedge core_clk) disable iff (!nrst) start_rd);
  cov_late:  cover property (@(posedge core_clk) disable iff (!nrst)
    set_mwe ##5 (wr_ctl && req.wdata[CTL_WRITE_BIT]));
  cov_rd_refused: cover property (@(posedge core_clk) disable iff (!nrst)
    wr_ctl && req.wdata[CTL_READ_BIT] && busy);

endmodule : nvac_top
`default_nettype wire

//--- verification/eeprom_access_control_tb.sv
// testbench: random and corner eeprom accesses through the cpu partner
`timescale 1ns/10ps
`default_nettype none
module eeprom_access_control_tb;
  import nvac_pkg::*;
  localparam int unsigned WC = 4;
  localparam int unsigned OD = 2;
  logic         core_clk = 1'b0, nrst = 1'b0, por_n = 1'b0, gie = 1'b0, pdr = 1'b0;
  logic         stall, rdy, osc, pd_ok;
  logic [7:0]   rdata, v;
  logic [7:0]   mem [NV_DEPTH];
  nvac_io_req_t req;
  int           fail_count = 0, compares = 0;
  bit           ok;
  always #4 core_clk = ~core_clk;
  nvac_top #(.WRITE_CYC(WC), .OSC_DIV(OD)) nvac_top_inst (
    .core_clk(core_clk), .nrst(nrst), .por_n(por_n), .io_wr(req.wr),
    .io_rd(req.rd), .io_sel(req.sel), .io_wdata(req.wdata),
    .global_irq_en(gie), .power_down_req(pdr), .io_rdata(rdata),
    .cpu_stall(stall), .ready_irq(rdy), .osc_run(osc), .power_down_ok(pd_ok));
  nvac_cpu_model nvac_cpu_model_inst (.core_clk(core_clk), .io_rdata(rdata), .req(req));
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic results();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  function automatic logic [7:0] ctl_expect(input bit rie, input bit mwe);
    return {4'h0, rie, mwe, 2'b00};
  endfunction : ctl_expect
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    nvac_cpu_model_inst.put(s, d);
  endtask : wr
  task automatic rchk(input logic [1:0] s, input logic [7:0] e, input string n);
    nvac_cpu_model_inst.get(s, v);
    check(n, v, e);
  endtask : rchk
  task automatic idle();
    nvac_cpu_model_inst.wait_idle(ok);
    fail_count += int'(!ok);
    if (!ok) results();
  endtask : idle
  // counts cycles that stall (w=0) or the oscillator (w=1) stays high
  task automatic run_len(input bit w, inout int n);
    while ((w ? osc : stall) === 1'b1 && n < 64) begin
      n++;
      @(negedge core_clk);
    end
  endtask : run_len
  initial begin
    int n;
    logic [8:0] a;
    logic [7:0] d;
    void'($urandom(42486));
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    por_n = 1'b1;
    rchk(REG_CONTROL, CONTROL_RESET, "ctl reset");
    wr(REG_ADDR_HIGH, 8'hff);
    rchk(REG_ADDR_HIGH, 8'h01, "addr high");
    gie = 1'b1;
    wr(REG_CONTROL, 8'hf8);
    rchk(REG_CONTROL, 8'h08, "ctl upper");
    check("ready idle", {7'h00, rdy}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : 9'($urandom_range(511));
      d = 8'($urandom);
      mem[a] = d;
      idle();
      gie = 1'b0;
      nvac_cpu_model_inst.nv_write(a, d);
      gie = 1'b1;
      n = 0;
      run_len(1'b0, n);
      check("wr stall", 8'(n), 8'(WR_STALL_CYC));
      check("ready busy", {7'h00, rdy}, 8'h00);
      if (i == 0) begin
        run_len(1'b1, n);
        check("wr time", {7'h00, n >= WC * OD - 2 && n <= WC * OD + 2}, 8'h01);
      end
      if (i == 2) begin
        pdr = 1'b1;
        wr(REG_ADDR_LOW, ~a[7:0]);
        check("pd hold", {6'h00, osc, pd_ok}, 8'h02);
      end
      if (i == 3) begin
        nrst = 1'b0;
        @(negedge core_clk);
        nrst = 1'b1;
      end
      if (i == 4) wr(REG_CONTROL, 8'h09);
      idle();
      check("ready done", {7'h00, rdy}, {7'h00, i != 3});
      check("pd done", {6'h00, osc, pd_ok}, {7'h00, i == 2});
      pdr = 1'b0;
      rchk(REG_ADDR_LOW, a[7:0], "addr held");
      rchk(REG_DATA, d, "data kept");
      wr(REG_CONTROL, 8'h09);
      n = 0;
      run_len(1'b0, n);
      check("rd stall", 8'(n), 8'(RD_STALL_CYC));
      rchk(REG_DATA, mem[a], "rd data");
      rchk(REG_CONTROL, ctl_expect(1'b1, 1'b0), "rd clear");
    end
    wr(REG_CONTROL, 8'h02);
    rchk(REG_CONTROL, 8'h00, "no mwe");
    wr(REG_CONTROL, 8'h04);
    rchk(REG_CONTROL, ctl_expect(1'b0, 1'b1), "mwe set");
    repeat (4) @(negedge core_clk);
    wr(REG_CONTROL, 8'h02);
    rchk(REG_CONTROL, 8'h00, "mwe late");
    check("ready off", {7'h00, rdy}, 8'h00);
    results();
  end
endmodule : eeprom_access_control_tb
`default_nettype wire

//--- verification/nvac_cpu_model.sv
// cpu-side partner: i/o register cycles and software sequences
`timescale 1ns/10ps
`default_nettype none
module nvac_cpu_model
  import nvac_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic [7:0]   io_rdata,
  output var  nvac_io_req_t req
);
  initial req = '0;
  task automatic put(input logic [1:0] s, input logic [7:0] d);
    @(negedge core_clk);
    req <= '{1'b1, 1'b0, s, d};
    @(negedge core_clk);
    // a released bus shows inverted values, never the last ones
    req <= '{1'b0, 1'b0, ~s, ~d};
  endtask : put
  task automatic get(input logic [1:0] s, output logic [7:0] d);
    @(negedge core_clk);
    req <= '{1'b0, 1'b1, s, ~req.wdata};
    @(negedge core_clk);
    d = io_rdata;
    req.rd <= 1'b0;
  endtask : get
  // no flash self-programming here, so only the write strobe is polled
  task automatic wait_idle(output bit ok);
    logic [7:0] c;
    ok = 1'b0;
    for (int i = 0; i < 64 && !ok; i++) begin
      get(REG_CONTROL, c);
      ok = (c[CTL_WRITE_BIT] === 1'b0);
    end
  endtask : wait_idle
  task automatic nv_write(input logic [8:0] a, input logic [7:0] d);
    put(REG_ADDR_HIGH, {7'h00, a[8]});
    put(REG_ADDR_LOW, a[7:0]);
    put(REG_DATA, d);
    put(REG_CONTROL, 8'h0c);
    put(REG_CONTROL, 8'h0a);
  endtask : nv_write
endmodule : nvac_cpu_model
`default_nettype wire
